// [hdl/cest_defs.svh]
// offsets, field positions, reset values and levels of the error-state tracker
`ifndef CEST_DEFS_SVH
`define CEST_DEFS_SVH

`define CEST_ADDR_W 8
`define CEST_OFF_IRQ_EN 8'h14
`define CEST_OFF_ERR_STS 8'h18
`define CEST_OFF_IRQ_STS 8'h20
`define CEST_OFF_IRQ_MASK 8'h24
`define CEST_RESET_WORD 32'h0000_0000

`define CEST_BIT_WARN 0
`define CEST_BIT_PASSIVE 1
`define CEST_BIT_BUS_OFF 2
`define CEST_LEC_LSB 4
`define CEST_LEC_MSB 6
`define CEST_TEC_LSB 16
`define CEST_TEC_MSB 23
`define CEST_REC_LSB 24
`define CEST_REC_MSB 31
`define CEST_EN_LSB 8
`define CEST_EN_MSB 11
`define CEST_BIT_COMB 0

`define CEST_WARN_LVL 9'h060
`define CEST_PASSIVE_LVL 9'h07F
`define CEST_TEC_MAX 10'h0FF
`define CEST_REC_ABOVE 8'h7F
`define CEST_REC_RELOAD 8'h78
`define CEST_REC_SAT 9'h0FF
`define CEST_TX_INC 10'h008
`define CEST_RX_INC_BIG 9'h008
`define CEST_RX_INC_SMALL 9'h001

`define CEST_CODE_NONE 3'h0
`define CEST_CODE_STUFF 3'h1
`define CEST_CODE_FORM 3'h2
`define CEST_CODE_ACK 3'h3
`define CEST_CODE_BIT_REC 3'h4
`define CEST_CODE_BIT_DOM 3'h5
`define CEST_CODE_CRC 3'h6

`define CEST_RESP_OKAY 2'h0
`define CEST_RESP_SLVERR 2'h2

`endif

// [hdl/cest_pkg.sv]
// types shared by the error-state tracker modules
`default_nettype none
package cest_pkg;

    typedef enum logic [2:0] {
        CEST_KIND_STUFF,
        CEST_KIND_FORM,
        CEST_KIND_ACK,
        CEST_KIND_BIT_REC,
        CEST_KIND_BIT_DOM,
        CEST_KIND_CRC
    } cest_fault_kind_e;

    // one-cycle event pulses from the protocol engine
    typedef struct packed {
        logic tx_ok;
        logic rx_ok;
        logic err_valid;
        cest_fault_kind_e err_kind;
        logic err_is_tx;
        logic rx_plus8;
        logic recovered;
    } cest_event_s;

    typedef struct packed {
        logic [8:0] tec;
        logic [7:0] rec;
        logic bus_off;
    } cest_cnt_s;

    typedef struct packed {
        logic bus_off;
        logic passive;
        logic warn;
    } cest_flags_s;

endpackage
`default_nettype wire

// [hdl/cest_fault_counters.sv]
// transmit and receive fault counters with bus-off state
`default_nettype none
`include "cest_defs.svh"
module cest_fault_counters (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire cest_pkg::cest_event_s ev,
    output cest_pkg::cest_cnt_s cnt
);
    cest_pkg::cest_cnt_s s_q;
    cest_pkg::cest_cnt_s s_d;

    // counter update; a node that is bus-off ignores traffic until recovery
    always_comb
    begin
        logic [9:0] tsum;
        logic [8:0] rsum;
        tsum = {1'b0, s_q.tec} + `CEST_TX_INC;
        rsum = {1'b0, s_q.rec} + (ev.rx_plus8 ? `CEST_RX_INC_BIG : `CEST_RX_INC_SMALL);
        s_d = s_q;
        if (s_q.bus_off)
        begin
            if (ev.recovered)
            begin
                s_d = '0;
            end
        end
        else
        begin
            if (ev.err_valid && ev.err_is_tx)
            begin
                s_d.tec = tsum[8:0];
                if (tsum > `CEST_TEC_MAX)
                begin
                    s_d.bus_off = 1'b1;
                end
            end
            else if (ev.tx_ok && s_q.tec != 9'h000)
            begin
                s_d.tec = s_q.tec - 9'h001;
            end
            if (ev.err_valid && !ev.err_is_tx)
            begin
                // saturate rather than wrap, a wrap would look like recovery
                s_d.rec = (rsum > `CEST_REC_SAT) ? 8'hFF : rsum[7:0];
            end
            else if (ev.rx_ok)
            begin
                if (s_q.rec > `CEST_REC_ABOVE)
                begin
                    s_d.rec = `CEST_REC_RELOAD;
                end
                else if (s_q.rec != 8'h00)
                begin
                    s_d.rec = s_q.rec - 8'h01;
                end
            end
        end
    end

    // state register, zero after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign cnt = s_q;
endmodule // cest_fault_counters
`default_nettype wire

// [hdl/cest_error_tracker.sv]
// CAN error-state tracker: counters, level flags, last fault code and AXI4-Lite registers
//
// Summary of operation
// - warn flag set when either fault counter is 96 or more.
// - passive flag set when either fault counter is 127 or more.
// - transmit count above 255 enters bus-off; flag shows bus-off state.
// - a detected bus fault writes its category code into bits 6:4.
// - a clean transmit or receive clears the last fault code to zero.
// - codes: 000 none, 001 stuffing, 010 form.
// - codes: 100 recessive bit, 101 dominant bit, 110 CRC.
// - software may write the last fault code; 111 is reserved for software.
// - 9-bit transmit count, low eight bits read-only at bits 23:16.
// - transmit count follows CAN transmitter fault confinement.
// - receive count read-only at bits 31:24; faults add 1 or 8.
// - receive count between 1 and 127 drops by one after each clean reception.
// - clean reception with receive count above 127 reloads 120.
// - error status at 0x18, all zero after reset.
// - rising warn, passive, bus-off flags set combined flag when enabled.
// - a new hardware fault code sets combined flag when its enable is set.
// - interrupt request only while combined flag and global enable are set.
`default_nettype none
`include "cest_defs.svh"
module cest_error_tracker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire cest_pkg::cest_event_s ev,
    output cest_pkg::cest_flags_s flags,
    output logic irq,
    input wire logic [`CEST_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CEST_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // every register of the slave lives in one struct so reset and ce act on all of it alike
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [`CEST_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] lec;
        logic [3:0] en;
        logic comb;
        logic mask;
        cest_pkg::cest_flags_s fl;
    } cest_top_s;

    cest_top_s s_q;
    cest_top_s s_d;
    cest_pkg::cest_cnt_s cnt;

    // true when either counter is at or above a level
    // a nine-bit compare, so a bus-off transmit count still counts as above both levels
    function automatic logic at_level(input logic [8:0] tec, input logic [7:0] rec, input logic [8:0] lvl);
        at_level = (tec >= lvl) || ({1'b0, rec} >= lvl);
    endfunction

    // true for every register the slave answers with OKAY
    // anything else answers SLVERR and reads as zero
    function automatic logic is_mapped(input logic [`CEST_ADDR_W-1:0] a);
        if (a == `CEST_OFF_IRQ_EN)
        begin
            is_mapped = 1'b1;
        end
        else if (a == `CEST_OFF_ERR_STS)
        begin
            is_mapped = 1'b1;
        end
        else if (a == `CEST_OFF_IRQ_STS)
        begin
            is_mapped = 1'b1;
        end
        else if (a == `CEST_OFF_IRQ_MASK)
        begin
            is_mapped = 1'b1;
        end
        else
        begin
            is_mapped = 1'b0;
        end
    endfunction

    // category of a detected fault to its last-code value
    function automatic logic [2:0] kind_code(input cest_pkg::cest_fault_kind_e k);
        case (k)
            cest_pkg::CEST_KIND_STUFF: kind_code = `CEST_CODE_STUFF;
            cest_pkg::CEST_KIND_FORM: kind_code = `CEST_CODE_FORM;
            cest_pkg::CEST_KIND_ACK: kind_code = `CEST_CODE_ACK;
            cest_pkg::CEST_KIND_BIT_REC: kind_code = `CEST_CODE_BIT_REC;
            cest_pkg::CEST_KIND_BIT_DOM: kind_code = `CEST_CODE_BIT_DOM;
            cest_pkg::CEST_KIND_CRC: kind_code = `CEST_CODE_CRC;
            default: kind_code = `CEST_CODE_NONE;
        endcase
    endfunction

    // counters sit in their own module so their arithmetic stays apart from the bus logic
    cest_fault_counters u_counters (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .ev(ev),
        .cnt(cnt)
    );

    // handshakes are gated by ce so nothing is accepted while state is frozen
    assign s_axi_awready = ce && !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = ce && !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = ce && !s_q.rvalid;
    assign s_axi_bvalid = ce && s_q.bvalid;
    assign s_axi_rvalid = ce && s_q.rvalid;

    // response payloads straight from registers, stable while valid stands
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // flags and interrupt request are registered levels
    assign flags = s_q.fl;
    assign irq = s_q.comb && s_q.mask;

    // next state: bus slave, level flags, last code, interrupt flag
    always_comb
    begin
        logic aw_now;
        logic w_now;
        logic do_wr;
        logic [`CEST_ADDR_W-1:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [31:0] rd;
        cest_pkg::cest_flags_s nf;
        logic rise_any;
        logic hw_code;
        s_d = s_q;
        nf = '0;
        rise_any = 1'b0;
        hw_code = 1'b0;
        // handshakes of this cycle; a channel taken now counts as held
        aw_now = s_axi_awvalid && s_axi_awready;
        w_now = s_axi_wvalid && s_axi_wready;
        wa = aw_now ? s_axi_awaddr : s_q.awaddr;
        wd = w_now ? s_axi_wdata : s_q.wdata;
        ws = w_now ? s_axi_wstrb : s_q.wstrb;
        do_wr = (s_q.aw_got || aw_now) && (s_q.w_got || w_now);
        // unmapped addresses and reserved bits read as zero
        rd = `CEST_RESET_WORD;

        // hold each half until its partner arrives
        if (aw_now)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (w_now)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end

        // register writes; hardware updates below take precedence
        if (do_wr)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = is_mapped(wa) ? `CEST_RESP_OKAY : `CEST_RESP_SLVERR;
            // decode by address; an unmapped write only gets its SLVERR response
            if (wa == `CEST_OFF_IRQ_EN)
            begin
                if (ws[1])
                begin
                    s_d.en = wd[`CEST_EN_MSB:`CEST_EN_LSB];
                end
            end
            else if (wa == `CEST_OFF_ERR_STS)
            begin
                if (ws[0])
                begin
                    s_d.lec = wd[`CEST_LEC_MSB:`CEST_LEC_LSB];
                end
            end
            else if (wa == `CEST_OFF_IRQ_STS)
            begin
                if (ws[0] && wd[`CEST_BIT_COMB])
                begin
                    s_d.comb = 1'b0;
                end
            end
            else if (wa == `CEST_OFF_IRQ_MASK)
            begin
                if (ws[0])
                begin
                    s_d.mask = wd[`CEST_BIT_COMB];
                end
            end
        end

        // response leaves once the master takes it
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end

        // read data captured at the address handshake
        if (s_axi_araddr == `CEST_OFF_IRQ_EN)
        begin
            rd[`CEST_EN_MSB:`CEST_EN_LSB] = s_q.en;
        end
        else if (s_axi_araddr == `CEST_OFF_ERR_STS)
        begin
            rd[`CEST_BIT_WARN] = s_q.fl.warn;
            rd[`CEST_BIT_PASSIVE] = s_q.fl.passive;
            rd[`CEST_BIT_BUS_OFF] = s_q.fl.bus_off;
            rd[`CEST_LEC_MSB:`CEST_LEC_LSB] = s_q.lec;
            rd[`CEST_TEC_MSB:`CEST_TEC_LSB] = cnt.tec[7:0];
            rd[`CEST_REC_MSB:`CEST_REC_LSB] = cnt.rec;
        end
        else if (s_axi_araddr == `CEST_OFF_IRQ_STS)
        begin
            rd[`CEST_BIT_COMB] = s_q.comb;
        end
        else if (s_axi_araddr == `CEST_OFF_IRQ_MASK)
        begin
            rd[`CEST_BIT_COMB] = s_q.mask;
        end

        // a read answers with the word decoded at its taking edge
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd;
            s_d.rresp = is_mapped(s_axi_araddr) ? `CEST_RESP_OKAY : `CEST_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end

        // level flags follow the counters one cycle later
        nf.warn = at_level(cnt.tec, cnt.rec, `CEST_WARN_LVL);
        nf.passive = at_level(cnt.tec, cnt.rec, `CEST_PASSIVE_LVL);
        // bus-off comes from the counter module, which keeps it until recovery
        nf.bus_off = cnt.bus_off;
        s_d.fl = nf;

        // a fault wins over a clean frame and over a software write
        hw_code = ev.err_valid;
        if (ev.err_valid)
        begin
            s_d.lec = kind_code(ev.err_kind);
        end
        else if (ev.tx_ok || ev.rx_ok)
        begin
            s_d.lec = `CEST_CODE_NONE;
        end

        // only rising flags count, a flag that stays set raises nothing new
        rise_any = (s_q.en[0] && nf.warn && !s_q.fl.warn)
            || (s_q.en[1] && nf.passive && !s_q.fl.passive)
            || (s_q.en[2] && nf.bus_off && !s_q.fl.bus_off);
        // the set comes after the software clear above, so an event in the clear cycle is kept
        if (rise_any || (hw_code && s_q.en[3]))
        begin
            s_d.comb = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end
endmodule // cest_error_tracker
`default_nettype wire

// [verif/cest_error_tracker_asserts.sv]
// port-level assertions for the error-state tracker
`default_nettype none
`include "cest_defs.svh"
module cest_error_tracker_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire cest_pkg::cest_flags_s flags,
    input wire logic irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [`CEST_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // levels and handshakes
    reset_quiet_a:
        assert property ($rose(aresetn) |-> !irq && flags == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not clear after reset");
    warn_nested_a:
        assert property (flags.passive |-> flags.warn) else $error("passive without warn");
    off_nested_a:
        assert property (flags.bus_off |-> flags.passive) else $error("bus-off without passive");
    // a frozen block must neither take nor answer anything
    frozen_idle_a:
        assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready
            && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus active while frozen");
    // flags are registers, so a read shows the value of its taking edge
    status_read_a:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `CEST_OFF_ERR_STS
            |=> s_axi_rdata[3:0] == {1'h0, $past(flags)} && s_axi_rdata[15:7] == 9'h000)
        else $error("status read disagrees with flags");
    unmapped_zero_a:
        assert property (s_axi_rvalid && s_axi_rresp == `CEST_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read returned data");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid || !ce) else $error("read not answered");
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid || !ce)
        else $error("write not answered");
    write_busy_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    read_done_a:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !$past(s_axi_arready))
        else $error("read answered twice");
endmodule // cest_error_tracker_chk

bind cest_error_tracker cest_error_tracker_chk i_cest_error_tracker_chk (.aclk, .aresetn, .ce, .flags, .irq,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [verif/cest_can_node.sv]
// far-side model: the bus and protocol engine as a source of event pulses
`default_nettype none
module cest_can_node (
    input wire logic aclk,
    output cest_pkg::cest_event_s ev
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ev = '0;
    // one single-cycle pulse per call, then idle so counters and flags settle
    task automatic send(input cest_pkg::cest_event_s e);
        @(posedge aclk);
        ev <= e;
        @(posedge aclk);
        ev <= '0;
        repeat (2) @(posedge aclk);
    endtask
endmodule // cest_can_node
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the error-state tracker
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic ce = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    cest_pkg::cest_event_s ev;
    cest_pkg::cest_flags_s flags;
    int mismatches = 0, total_checks = 0;
    // reference state of the counters and the last code
    logic [8:0] m_tec = 9'h000;
    logic [7:0] m_rec = 8'h00;
    logic [2:0] m_lec = 3'h0;
    logic m_boff = 1'h0;
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    localparam cest_pkg::cest_event_s ev_tx_ok = 9'h100;
    localparam cest_pkg::cest_event_s ev_rx_ok = 9'h080;
    localparam cest_pkg::cest_event_s ev_recovered = 9'h001;

    always #12.5 aclk = ~aclk;

    cest_error_tracker i_cest_error_tracker (.aclk, .aresetn, .ce, .ev, .flags, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    cest_can_node i_cest_can_node (.aclk, .ev);

    // shared compare, bus cycles and reference model
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // handshakes are judged on settled values half a cycle before the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'h0;
            if (w_hs) s_axi_wvalid <= 1'h0;
        end while (!b_hs);
        s_axi_bready <= 1'h0;
        chk({30'h0, r}, {30'h0, er}, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'h0;
        end while (!r_hs);
        s_axi_rready <= 1'h0;
        chk(d, ed, "read data");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask
    task automatic irq_chk(input logic x);
        repeat (3) @(negedge aclk);
        chk({31'h0, irq}, {31'h0, x}, "interrupt");
    endtask
    function automatic cest_pkg::cest_event_s flt(input int k, input logic tx, input logic p8);
        flt = '0;
        flt.err_valid = 1'h1;
        flt.err_kind = cest_pkg::cest_fault_kind_e'(k[2:0]);
        flt.err_is_tx = tx;
        flt.rx_plus8 = p8;
    endfunction
    function automatic logic [31:0] exp_sts();
        logic w, p;
        w = m_tec >= 9'h060 || m_rec >= 8'h60;
        p = m_tec >= 9'h07F || m_rec >= 8'h7F;
        return {m_rec, m_tec[7:0], 9'h000, m_lec, 1'h0, m_boff, p, w};
    endfunction
    // bus-off freezes the counters until recovery
    task automatic act(input cest_pkg::cest_event_s e);
        logic [8:0] r;
        if (m_boff)
        begin
            if (e.recovered) {m_tec, m_rec, m_boff} = '0;
        end
        else if (e.err_valid)
        begin
            m_lec = codes[e.err_kind];
            r = {1'h0, m_rec} + (e.rx_plus8 ? 9'h008 : 9'h001);
            if (e.err_is_tx) m_tec = m_tec + 9'h008;
            else m_rec = r > 9'h0FF ? 8'hFF : r[7:0];
            m_boff = m_tec > 9'h0FF;
        end
        else
        begin
            if (e.tx_ok || e.rx_ok) m_lec = 3'h0;
            if (e.tx_ok && m_tec != 9'h000) m_tec = m_tec - 9'h001;
            if (e.rx_ok) m_rec = m_rec > 8'h7F ? 8'h78 : (m_rec != 8'h00 ? m_rec - 8'h01 : 8'h00);
        end
        i_cest_can_node.send(e);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // main sequence: reset map, software code, interrupts, counters, random traffic
    initial
    begin
        cest_pkg::cest_event_s e;
        logic [7:0] regs [4] = '{8'h14, 8'h18, 8'h20, 8'h24};
        void'($urandom(83));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (regs[i]) rd(regs[i], 32'h0000_0000, 2'h0);
        rd(8'h30, 32'h0000_0000, 2'h2);
        wr(8'h30, 32'hFFFF_FFFF, 2'h2);
        wr(8'h18, 32'hFFFF_FFFF, 2'h0);
        rd(8'h18, 32'h0000_0070, 2'h0);
        m_lec = 3'h7;
        act(ev_rx_ok);
        rd(8'h18, exp_sts(), 2'h0);
        $display("test map and software code done");
        wr(8'h14, 32'h0000_0800, 2'h0);
        wr(8'h24, 32'h0000_0001, 2'h0);
        act(flt(1, 1'h0, 1'h0));
        irq_chk(1'h1);
        rd(8'h20, 32'h0000_0001, 2'h0);
        wr(8'h20, 32'h0000_0001, 2'h0);
        wr(8'h24, 32'h0000_0000, 2'h0);
        act(flt(5, 1'h1, 1'h0));
        irq_chk(1'h0);
        wr(8'h24, 32'h0000_0001, 2'h0);
        irq_chk(1'h1);
        wr(8'h14, 32'h0000_0100, 2'h0);
        wr(8'h20, 32'h0000_0001, 2'h0);
        irq_chk(1'h0);
        while (!flags.warn) act(flt(0, 1'h0, 1'h1));
        irq_chk(1'h1);
        rd(8'h18, exp_sts(), 2'h0);
        $display("test interrupts done");
        repeat (6) act(flt(4, 1'h0, 1'h1));
        act(ev_rx_ok);
        rd(8'h18, exp_sts(), 2'h0);
        while (!m_boff) act(flt(3, 1'h1, 1'h0));
        rd(8'h18, exp_sts(), 2'h0);
        chk({29'h0, flags}, 32'h0000_0007, "flags at bus-off");
        act(ev_recovered);
        rd(8'h18, exp_sts(), 2'h0);
        // a frozen block drops an event and refuses the bus, the model is left alone
        @(posedge aclk);
        ce <= 1'h0;
        i_cest_can_node.send(flt(5, 1'h1, 1'h0));
        chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0000_0000, "ready while frozen");
        ce <= 1'h1;
        rd(8'h18, exp_sts(), 2'h0);
        $display("test directed counters done");
        for (int i = 0; i < 200; i++)
        begin
            e = flt($urandom_range(0, 5), 1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)));
            case ($urandom_range(0, 4))
                0: e = ev_tx_ok;
                1: e = ev_rx_ok;
                default: ;
            endcase
            if (m_boff) e = ev_recovered;
            act(e);
            rd(8'h18, exp_sts(), 2'h0);
        end
        $display("test random events done");
        end_sim();
    end

    // watchdog well beyond the few thousand cycles the run needs
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
